// >>> byte_port_checker.sv
`timescale 1ns/100ps
module byte_port_checker (
    input wire logic        sys_clk,       // Clock.
    input wire logic        rst,           // Reset.
    input wire logic [31:0] s_axi_awaddr,  // Write address.
    input wire logic        s_axi_awvalid, // Address valid.
    input wire logic        s_axi_awready, // Address ready.
    input wire logic [31:0] s_axi_wdata,   // Write data.
    input wire logic        s_axi_wvalid,  // Data valid.
    input wire logic        s_axi_wready,  // Data ready.
    input wire logic        s_axi_bvalid,  // Response valid.
    input wire logic        s_axi_bready,  // Response ready.
    input wire logic        s_axi_arvalid, // Read valid.
    input wire logic        s_axi_arready, // Read ready.
    input wire logic [31:0] s_axi_rdata,   // Read data.
    input wire logic        s_axi_rvalid,  // Read data valid.
    input wire logic        s_axi_rready,  // Read data ready.
    input wire logic [7:0]  port8_oe,      // Byte port enables.
    input wire logic [2:0]  port3_oe,      // Small port enables.
    input wire logic        irq            // Interrupt.
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [11:0] aw_ff;
    logic [7:0]  wd_ff;
    logic [7:0]  dir8_ff;
    logic [2:0]  dir3_ff;
    logic        sel_ff;
    logic [3:0]  since_w_ff;
    // Shadow direction registers, updated when a write response is taken.
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_ff <= 12'h000;
            wd_ff <= 8'h00;
            dir8_ff <= 8'hFF;
            dir3_ff <= 3'h7;
            sel_ff <= 1'b0;
            since_w_ff <= 4'hF;
        end else begin
            if (s_axi_awvalid && s_axi_awready) aw_ff <= s_axi_awaddr[11:0];
            if (s_axi_wvalid && s_axi_wready) wd_ff <= s_axi_wdata[7:0];
            if (s_axi_bvalid && s_axi_bready && aw_ff == 12'h220) dir8_ff <= wd_ff;
            if (s_axi_bvalid && s_axi_bready && aw_ff == 12'h224) begin
                dir3_ff <= wd_ff[2:0];
                sel_ff <= wd_ff[4];
            end
            if (s_axi_wvalid && s_axi_wready) since_w_ff <= 4'h0;
            else if (since_w_ff != 4'hF) since_w_ff <= since_w_ff + 4'h1;
        end
    end
    sequence aw_w_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence settled;
        !s_axi_bvalid && since_w_ff > 4'h3;
    endsequence
    a_write_resp_lat: assert property (aw_w_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
    a_read_lat: assert property (ar_taken |=> s_axi_rvalid) else $error("read answer late");
    a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready))
        else $error("read answer without request");
    a_bresp_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("bvalid stuck");
    a_rresp_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("rdata upper set");
    a_gpio_dir: assert property (settled and !sel_ff |-> port8_oe == ~dir8_ff)
        else $error("byte port enables differ from direction");
    a_small_dir: assert property (settled |-> port3_oe == ~dir3_ff)
        else $error("small port enables differ from direction");
    a_irq_clear: assert property ($fell(irq) |-> since_w_ff < 4'h5)
        else $error("irq fell without a write");
endmodule

// >>> byte_port_regs.vh
`ifndef BYTE_PORT_REGS_VH
`define BYTE_PORT_REGS_VH

// Register indexes as printed; the byte address is four times the index.
`define IDX_EIGHT_BIT_PORT_PINS   8'h08
`define IDX_THREE_PIN_PORT_PINS   8'h09
`define IDX_PERIPHERAL_IRQ_FLAGS  8'h0C
`define IDX_EIGHT_BIT_PORT_DIR    8'h88
`define IDX_SMALL_PORT_DIR_STAT   8'h89
`define IDX_PERIPHERAL_IRQ_ENA    8'h8C
`define IDX_ANALOG_PIN_SELECT     8'h9F

// Field positions of the small-port direction and host status register, and of the host port interrupt bit.
`define BIT_INPUT_BUFFER_FULL     7
`define BIT_OUTPUT_BUFFER_FULL    6
`define BIT_INPUT_OVERFLOW        5
`define BIT_HOST_PORT_SELECT      4
`define BIT_HOST_PORT_IRQ         7

// Positions of the host control inputs on the three-pin port.
`define PIN_HOST_READ             0
`define PIN_HOST_WRITE            1
`define PIN_HOST_SELECT           2

// Reset values.
`define RST_EIGHT_BIT_PORT_DIR    8'hFF
`define RST_SMALL_PORT_DIR        3'h7
`define RST_IRQ_FLAGS             1'h0
`define RST_IRQ_ENA               1'h0
`define RST_ANALOG_PIN_SELECT     3'h0

// Bus response codes.
`define RESP_OKAY                 2'h0
`define RESP_SLVERR               2'h2

`endif

// >>> byte_port_top.v
// Behaviour
// [RULE1] Eight port pins each have their own direction bit.
// [RULE2] Setting the host port select bit turns the eight-bit port into a byte-wide slave port for a host.
// [RULE3] In byte-port mode pin n of the eight-bit port carries bit n of the host data byte.
// [RULE4] Three small-port pins each have their own direction bit.
// [RULE5] In byte-port mode the three small pins act as host read strobe, write strobe and chip select.
// [RULE6] Software must make the three control pins digital inputs before using byte-port mode.
// [RULE7] A small-port pin selected as analog reads back as zero.
// [RULE8] Small-port direction bits drive the pin enables even when the pin is analog.
// [RULE9] After reset the small-port pins are analog and read as zero.
// [RULE10] The small-port direction register holds buffer full, overflow, select and three direction bits.
// [RULE11] The eight-bit direction register resets to all ones.
// [RULE12] The host port interrupt flag and enable sit at bit 7 of the shared flag and enable registers.
// [RULE13] A direction bit of one makes the pin an input and zero drives the output latch.
// [RULE14] Buffer full and overflow bits follow host strobes, software writes to full bits are ignored.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`include "byte_port_regs.vh"

module byte_port_top (
    input  wire        sys_clk,       // Core clock, 20 MHz.
    input  wire        rst,           // Asynchronous reset, active high.
    input  wire [31:0] s_axi_awaddr,  // Write address.
    input  wire        s_axi_awvalid, // Write address valid.
    output reg         s_axi_awready, // Write address ready.
    input  wire [31:0] s_axi_wdata,   // Write data.
    input  wire [3:0]  s_axi_wstrb,   // Write byte enables.
    input  wire        s_axi_wvalid,  // Write data valid.
    output reg         s_axi_wready,  // Write data ready.
    output reg  [1:0]  s_axi_bresp,   // Write response.
    output reg         s_axi_bvalid,  // Write response valid.
    input  wire        s_axi_bready,  // Write response ready.
    input  wire [31:0] s_axi_araddr,  // Read address.
    input  wire        s_axi_arvalid, // Read address valid.
    output reg         s_axi_arready, // Read address ready.
    output reg  [31:0] s_axi_rdata,   // Read data.
    output reg  [1:0]  s_axi_rresp,   // Read response.
    output reg         s_axi_rvalid,  // Read data valid.
    input  wire        s_axi_rready,  // Read data ready.
    input  wire [7:0]  port8_in,      // Eight-bit port pin levels.
    output reg  [7:0]  port8_out,     // Eight-bit port drive values.
    output reg  [7:0]  port8_oe,      // Eight-bit port output enables.
    input  wire [2:0]  port3_in,      // Three-pin port pin levels.
    output reg  [2:0]  port3_out,     // Three-pin port drive values.
    output reg  [2:0]  port3_oe,      // Three-pin port output enables.
    output reg         irq            // Level interrupt, high while enabled flag set.
);

    // Returns the mask of small-port pins that are analog for a select code.
    function [2:0] analog_mask;
        input [2:0] cfg;
        begin
            analog_mask = (cfg < 3'h2) ? 3'h7 : 3'h0;
        end
    endfunction

    // Returns the register index addressed by a byte address, or ones if unaligned or out of range.
    function [7:0] reg_index;
        input [31:0] addr;
        begin
            if (addr[1:0] != 2'h0 || addr[31:10] != 22'h0) begin
                reg_index = 8'hFF;
            end else begin
                reg_index = addr[9:2];
            end
        end
    endfunction

    // Port latches, directions, host status and interrupt state.
    reg  [7:0] port8_latch_ff;
    reg  [2:0] port3_latch_ff;
    reg  [7:0] port8_dir_ff;
    reg  [2:0] port3_dir_ff;
    reg        host_select_ff;
    reg        in_full_ff;
    reg        out_full_ff;
    reg        overflow_ff;
    reg  [7:0] in_buf_ff;
    reg        irq_flag_ff;
    reg        irq_ena_ff;
    reg  [2:0] analog_sel_ff;

    // Write address and data are each held until both have arrived.
    reg        aw_held_ff;
    reg        w_held_ff;
    reg  [7:0] aw_idx_ff;
    reg  [7:0] wdata_ff;
    reg        wstrb0_ff;

    // Decoded configuration, host strobe events and bus handshakes.
    wire [2:0] analog_now;
    wire       host_mode;
    wire       host_read_active;
    wire       host_write_done;
    wire       host_read_done;
    wire       wr_fire;
    wire       wr_hit;
    wire       rd_fire;
    wire [7:0] ar_idx;

    // Read mux outputs, settled before the read address is taken.
    reg  [7:0] rd_val;
    reg        rd_ok;

    assign analog_now = analog_mask(analog_sel_ff);
    assign host_mode  = host_select_ff; // [RULE2]

    // Control pins only count as strobes when they read as digital.
    // An analog pin is seen as released, since a zero there would look like an active strobe.
    host_strobe_decode u_strobe (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .enable      (host_mode),
        .ctrl_pins   (port3_in | analog_now), // [RULE5] [RULE6]
        .read_active (host_read_active),
        .write_done  (host_write_done),
        .read_done   (host_read_done)
    );

    // A write goes ahead once address and data have both arrived.
    assign wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid;
    assign wr_hit  = wr_fire & wstrb0_ff;
    assign rd_fire = s_axi_arvalid & s_axi_arready;
    assign ar_idx  = reg_index(s_axi_araddr);

    // Write address and write data channels are taken independently.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_held_ff    <= 1'b0;
            w_held_ff     <= 1'b0;
            aw_idx_ff     <= 8'h00;
            wdata_ff      <= 8'h00;
            wstrb0_ff     <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= ~aw_held_ff & ~(s_axi_awvalid & s_axi_awready);
            s_axi_wready  <= ~w_held_ff & ~(s_axi_wvalid & s_axi_wready);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_ff <= 1'b1;
                aw_idx_ff  <= reg_index(s_axi_awaddr);
            end else if (wr_fire) begin
                aw_held_ff <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_ff <= 1'b1;
                wdata_ff  <= s_axi_wdata[7:0];
                wstrb0_ff <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_held_ff <= 1'b0;
            end
        end
    end

    // Write response, error for an unmapped index.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            case (aw_idx_ff)
                `IDX_EIGHT_BIT_PORT_PINS, `IDX_THREE_PIN_PORT_PINS, `IDX_PERIPHERAL_IRQ_FLAGS,
                `IDX_EIGHT_BIT_PORT_DIR, `IDX_SMALL_PORT_DIR_STAT, `IDX_PERIPHERAL_IRQ_ENA,
                `IDX_ANALOG_PIN_SELECT: s_axi_bresp <= `RESP_OKAY;
                default: s_axi_bresp <= `RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Software-written configuration and latches.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port8_latch_ff <= 8'h00;
            port3_latch_ff <= 3'h0;
            port8_dir_ff   <= `RST_EIGHT_BIT_PORT_DIR; // [RULE11]
            port3_dir_ff   <= `RST_SMALL_PORT_DIR;     // [RULE10]
            host_select_ff <= 1'b0;
            irq_ena_ff     <= `RST_IRQ_ENA;
            analog_sel_ff  <= `RST_ANALOG_PIN_SELECT;  // [RULE9]
        end else if (wr_hit) begin
            case (aw_idx_ff)
                `IDX_EIGHT_BIT_PORT_PINS: port8_latch_ff <= wdata_ff;
                `IDX_THREE_PIN_PORT_PINS: port3_latch_ff <= wdata_ff[2:0];
                `IDX_EIGHT_BIT_PORT_DIR:  port8_dir_ff <= wdata_ff; // [RULE1]
                `IDX_SMALL_PORT_DIR_STAT: begin
                    port3_dir_ff   <= wdata_ff[2:0]; // [RULE4]
                    host_select_ff <= wdata_ff[`BIT_HOST_PORT_SELECT];
                end
                `IDX_PERIPHERAL_IRQ_ENA:  irq_ena_ff <= wdata_ff[`BIT_HOST_PORT_IRQ]; // [RULE12]
                `IDX_ANALOG_PIN_SELECT:   analog_sel_ff <= wdata_ff[2:0];
                default: port8_latch_ff <= port8_latch_ff;
            endcase
        end
    end

    // Buffer status: sets win over clears in the same cycle.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            in_full_ff  <= 1'b0;
            out_full_ff <= 1'b0;
            overflow_ff <= 1'b0;
            in_buf_ff   <= 8'h00;
        end else begin
            // A finished host write loads the byte; a software read empties the buffer.
            if (host_write_done) begin
                in_buf_ff  <= port8_in; // [RULE3]
                in_full_ff <= 1'b1;     // [RULE14]
            end else if (rd_fire && ar_idx == `IDX_EIGHT_BIT_PORT_PINS && host_mode) begin
                in_full_ff <= 1'b0;
            end
            // A host write onto a full buffer marks the overrun.
            if (host_write_done && in_full_ff) begin
                overflow_ff <= 1'b1; // [RULE14]
            end else if (wr_hit && aw_idx_ff == `IDX_SMALL_PORT_DIR_STAT) begin
                overflow_ff <= wdata_ff[`BIT_INPUT_OVERFLOW];
            end
            // A software write offers a byte; the end of a host read takes it.
            if (wr_hit && aw_idx_ff == `IDX_EIGHT_BIT_PORT_PINS && host_mode) begin
                out_full_ff <= 1'b1;
            end else if (host_read_done) begin
                out_full_ff <= 1'b0; // [RULE14]
            end
        end
    end

    // Sticky interrupt flag, cleared by writing one; a new event beats the clear.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq_flag_ff <= `RST_IRQ_FLAGS;
            irq         <= 1'b0;
        end else begin
            if (host_write_done || host_read_done) begin
                irq_flag_ff <= 1'b1; // [RULE12]
            end else if (wr_hit && aw_idx_ff == `IDX_PERIPHERAL_IRQ_FLAGS
                         && wdata_ff[`BIT_HOST_PORT_IRQ]) begin
                irq_flag_ff <= 1'b0;
            end
            // Registered so the interrupt pin comes straight from a flip-flop.
            irq <= irq_flag_ff & irq_ena_ff;
        end
    end

    // Read data mux for the register map.
    always @* begin
        rd_val = 8'h00;
        rd_ok  = 1'b1;
        case (ar_idx)
            `IDX_EIGHT_BIT_PORT_PINS:  rd_val = host_mode ? in_buf_ff : port8_in; // [RULE3]
            `IDX_THREE_PIN_PORT_PINS:  rd_val = {5'h00, port3_in & ~analog_now}; // [RULE7] [RULE9]
            `IDX_PERIPHERAL_IRQ_FLAGS: rd_val = {irq_flag_ff, 7'h00};
            `IDX_EIGHT_BIT_PORT_DIR:   rd_val = port8_dir_ff;
            `IDX_SMALL_PORT_DIR_STAT:  rd_val = {in_full_ff, out_full_ff, overflow_ff,
                                                 host_select_ff, 1'b0, port3_dir_ff}; // [RULE10]
            `IDX_PERIPHERAL_IRQ_ENA:   rd_val = {irq_ena_ff, 7'h00};
            `IDX_ANALOG_PIN_SELECT:    rd_val = {5'h00, analog_sel_ff};
            default:                   rd_ok  = 1'b0;
        endcase
    end

    // Read channel answers one cycle after the address is taken.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            // A new address is refused while an answer still stands.
            s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_val};
                s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Pin drivers: direction one means input, zero drives the latch; in byte-port mode the eight-bit port drives only during a host read.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            port8_out <= 8'h00;
            port8_oe  <= 8'h00;
            port3_out <= 3'h0;
            port3_oe  <= 3'h0;
        end else begin
            port8_out <= port8_latch_ff;                          // [RULE3]
            port8_oe  <= host_mode ? {8{host_read_active}}
                                   : ~port8_dir_ff;               // [RULE13] [RULE2]
            port3_out <= port3_latch_ff;
            port3_oe  <= ~port3_dir_ff;                           // [RULE8] [RULE13]
        end
    end

endmodule

// >>> host_model.sv
`timescale 1ns/100ps
module host_model (
    input  wire logic       sys_clk, // Clock.
    input  wire logic [7:0] pins8,   // Resolved byte port levels.
    output logic      [7:0] ext8,    // Host drive on the byte port.
    output logic      [2:0] ctl      // Read, write, select strobes, low active.
);
    initial begin
        ext8 = 8'h00;
        ctl = 3'h7;
    end
    // Idle levels, used while the port is general I/O.
    task automatic set_pins(input logic [7:0] d, input logic [2:0] c);
        ext8 <= d;
        ctl <= c;
    endtask
    // Select and write low three cycles, then high three, data held meanwhile.
    task automatic host_write(input logic [7:0] d);
        ext8 <= d;
        ctl <= 3'b001;
        repeat (3) @(posedge sys_clk);
        ctl <= 3'b111;
        repeat (3) @(posedge sys_clk);
        ext8 <= ~d;
    endtask
    // Read releases the bus, so the line shows the inverse of the last value.
    task automatic host_read(output logic [7:0] d);
        ext8 <= ~ext8;
        ctl <= 3'b010;
        repeat (4) @(posedge sys_clk);
        d = pins8;
        ctl <= 3'b111;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule

// >>> host_strobe_decode.v
`timescale 1ns/100ps
`include "byte_port_regs.vh"

module host_strobe_decode (
    input  wire       sys_clk,     // Core clock.
    input  wire       rst,         // Asynchronous reset, active high.
    input  wire       enable,      // Byte-port mode, from the host port select bit alone.
    input  wire [2:0] ctrl_pins,   // Three-pin port input levels.
    output reg        read_active, // Host is reading the byte port.
    output reg        write_done,  // One-cycle pulse at the end of a host write.
    output reg        read_done    // One-cycle pulse at the end of a host read.
);

    reg  prev_wr_ff;
    reg  prev_rd_ff;
    wire sel_now;
    wire wr_now;
    wire rd_now;

    // Strobes and select are active low on the pins.
    assign sel_now = enable & ~ctrl_pins[`PIN_HOST_SELECT];
    assign wr_now  = sel_now & ~ctrl_pins[`PIN_HOST_WRITE];
    assign rd_now  = sel_now & ~ctrl_pins[`PIN_HOST_READ];

    // Remember last strobe state and detect strobe ends.
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prev_wr_ff  <= 1'b0;
            prev_rd_ff  <= 1'b0;
            read_active <= 1'b0;
            write_done  <= 1'b0;
            read_done   <= 1'b0;
        end else begin
            prev_wr_ff  <= wr_now;
            prev_rd_ff  <= rd_now;
            read_active <= rd_now;
            write_done  <= prev_wr_ff & ~wr_now;
            read_done   <= prev_rd_ff & ~rd_now;
        end
    end

endmodule

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
    logic        sys_clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, rv;
    logic [3:0]  s_axi_wstrb;
    logic [7:0]  hv;
    logic [7:0]  host_q[$];
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire  [1:0]  s_axi_bresp, s_axi_rresp;
    wire  [31:0] s_axi_rdata;
    wire  [7:0]  port8_out, port8_oe, ext8, port8_in;
    wire  [2:0]  port3_out, port3_oe, ctl, port3_in;
    integer      miscompares, check_count, seed, cyc, i, dir8, lat8, dir3, b;
    // Pins show the port where it drives, the host or idle level elsewhere.
    assign port8_in = (port8_oe & port8_out) | (~port8_oe & ext8);
    assign port3_in = (port3_oe & port3_out) | (~port3_oe & ctl);
    byte_port_top dut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .port8_in(port8_in), .port8_out(port8_out), .port8_oe(port8_oe), .port3_in(port3_in),
        .port3_out(port3_out), .port3_oe(port3_oe), .irq(irq));
    host_model host (.sys_clk(sys_clk), .pins8(port8_in), .ext8(ext8), .ctl(ctl));
    // Clock of 50 ns period.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Hang guard.
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            tally_and_finish;
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            miscompares = miscompares + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Register write; address and data released each at its own handshake.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        s_axi_awaddr <= {22'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        chk({30'h0, s_axi_bresp}, 32'h0);
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [7:0] idx, output logic [31:0] d, input logic [1:0] er);
        s_axi_araddr <= {22'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
        logic [31:0] d;
        rd(idx, d, er);
        chk(d, exp);
    endtask
    initial begin
        seed = 14;
        miscompares = 0;
        check_count = 0;
        cyc = 0;
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
        s_axi_wstrb = 4'hF;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        host.set_pins(8'h00, 3'h5);
        rdc(8'h88, 32'hFF, 2'h0);
        rdc(8'h89, 32'h07, 2'h0);
        rdc(8'h0C, 32'h00, 2'h0);
        rdc(8'h8C, 32'h00, 2'h0);
        rdc(8'h09, 32'h00, 2'h0);
        rdc(8'h01, 32'h00, 2'h2);
        $display("test reset values done");
        for (i = 0; i < 4; i = i + 1) begin
            dir8 = $random(seed) & 255;
            lat8 = $random(seed) & 255;
            b = $random(seed) & 255;
            host.set_pins(b[7:0], 3'h5);
            wr(8'h88, dir8[7:0]);
            wr(8'h08, lat8[7:0]);
            chk({24'h0, port8_oe}, ~dir8 & 255);
            chk({24'h0, port8_out}, lat8);
            rdc(8'h08, (lat8 & ~dir8 | b & dir8) & 255, 2'h0);
        end
        $display("test byte port io done");
        dir3 = $random(seed) & 7;
        host.set_pins(8'h00, 3'h3);
        wr(8'h9F, 8'h02);
        wr(8'h89, dir3[7:0]);
        wr(8'h09, 8'h05);
        chk({29'h0, port3_oe}, ~dir3 & 7);
        chk({29'h0, port3_out}, 32'h5);
        rdc(8'h09, (5 & ~dir3 | 3 & dir3) & 7, 2'h0);
        wr(8'h9F, 8'h01);
        rdc(8'h09, 32'h00, 2'h0);
        chk({29'h0, port3_oe}, ~dir3 & 7);
        $display("test small port done");
        host.set_pins(8'h00, 3'h7);
        wr(8'h88, 8'h00);
        wr(8'h89, 8'h17);
        wr(8'h9F, 8'h02);
        chk({24'h0, port8_oe}, 32'h0);
        wr(8'h8C, 8'h80);
        b = $random(seed) & 255;
        host_q.push_back(b[7:0]);
        host.host_write(b[7:0]);
        rdc(8'h89, 32'h97, 2'h0);
        chk({31'h0, irq}, 32'h1);
        wr(8'h8C, 8'h00);
        chk({31'h0, irq}, 32'h0);
        wr(8'h8C, 8'h80);
        rdc(8'h08, host_q.pop_front(), 2'h0);
        rdc(8'h89, 32'h17, 2'h0);
        host_q.push_back(8'h5A);
        host.host_write(8'h5A);
        host_q.push_back(8'hA5);
        host.host_write(8'hA5);
        rdc(8'h89, 32'hB7, 2'h0);
        wr(8'h89, 8'hD7);
        rdc(8'h89, 32'h97, 2'h0);
        rd(8'h08, rv, 2'h0);
        chk(rv, host_q.pop_back());
        host_q.delete();
        lat8 = $random(seed) & 255;
        wr(8'h08, lat8[7:0]);
        rdc(8'h89, 32'h57, 2'h0);
        host.host_read(hv);
        chk({24'h0, hv}, lat8);
        rdc(8'h89, 32'h17, 2'h0);
        wr(8'h0C, 8'h80);
        chk({31'h0, irq}, 32'h0);
        $display("test host port done");
        tally_and_finish;
    end
endmodule
bind byte_port_top byte_port_checker chk_u (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .port8_oe(port8_oe), .port3_oe(port3_oe), .irq(irq));
